/* design/qostg_pkg.sv */
// Purpose: Constants, types and helpers of the per-port QoS/tag block.
// Assumes: Byte-wide frame streams without FCS on the fabric side.
// Notes:   Offsets index 8-bit registers.
// Contract
// [RL1] Two control bits pick one, two, four queues.
// [RL2] Queue 3 highest, queue 0 lowest priority.
// [RL3] Unsplit port treats all frames equally.
// [RL4] Strict priority or weighted fair, 7-bit weights.
// [RL5] Global two-bit map folds priority into high/low.
// [RL6] Port-based priority gives port level 0-3.
// [RL7] Port priority 3 goes to high queue.
// [RL8] Tagged frames map 3-bit priority to level.
// [RL9] 802.1p classification needs control bit 5.
// [RL10] Tag is TPID 8100 then priority, flag, VID.
// [RL11] Bit 2 enables insertion, membership selects sources.
// [RL12] Untagged egress frames get source port tag.
// [RL13] Already tagged frames never get second tag.
// [RL14] Bit 1 strips tags, untagged pass unchanged.
// [RL15] Frame check sequence recomputed after tag change.
// [RL16] Cap bit 7 limits priority to default.
// [RL17] Default tag per port in two registers.
// [RL18] Four-queue mode: queue index equals priority.
// [RL19] DSCP six bits index 128-bit priority map.
package qostg_pkg;

	// ------------------------------
	// Register offsets
	// ------------------------------
	localparam logic [7:0] OFF_CTRL0 = 8'h00; // Port control 0.
	localparam logic [7:0] OFF_CTRL2 = 8'h02; // Priority cap.
	localparam logic [7:0] OFF_MEMB  = 8'h08; // Insert sources.
	localparam logic [7:0] OFF_CTRL9 = 8'h09; // Split high, WFQ.
	localparam logic [7:0] OFF_WGT   = 8'h0e; // Weights q3..q0.
	localparam logic [7:0] OFF_PMAP  = 8'h20; // 802.1p map, 2 B.
	localparam logic [7:0] OFF_GLOB  = 8'h22; // Two-queue map.
	localparam logic [7:0] OFF_DSCP  = 8'h30; // DSCP map, 16 B.
	localparam logic [7:0] OFF_DTAG  = 8'h40; // Default tags.
	localparam logic [7:0] OFF_STAT  = 8'h50; // Status.

	// ------------------------------
	// Field positions
	// ------------------------------
	localparam int B_SPLIT_LO = 0; // Control 0: split low bit.
	localparam int B_REMOVE   = 1; // Control 0: tag removal.
	localparam int B_INSERT   = 2; // Control 0: tag insertion.
	localparam int B_PPRIO    = 3; // Control 0: port level [4:3].
	localparam int B_DOT1P    = 5; // Control 0: 802.1p enable.
	localparam int B_DSCP     = 6; // Control 0: DSCP enable.
	localparam int B_CAP      = 7; // Control 2: priority cap.
	localparam int B_WFQ      = 0; // Control 9: weighted fair.
	localparam int B_SPLIT_HI = 1; // Control 9: split high bit.
	localparam int B_Q2MAP    = 6; // Global: map [7:6].

	// ------------------------------
	// Reset values and codes
	// ------------------------------
	localparam logic [7:0]  RST_CTRL = 8'h00; // All features off.
	localparam logic [4:0]  RST_MEMB = 5'h1f; // All sources.
	localparam logic [6:0]  RST_W3   = 7'h08; // Queue 3 weight.
	localparam logic [6:0]  RST_W2   = 7'h04; // Queue 2 weight.
	localparam logic [6:0]  RST_W1   = 7'h02; // Queue 1 weight.
	localparam logic [6:0]  RST_W0   = 7'h01; // Queue 0 weight.
	localparam logic [15:0] RST_PMAP = 16'hfa50; // Pairs of pcp.
	localparam logic [1:0]  RST_Q2M  = 2'h2; // Level 2+ is high.
	localparam logic [15:0] RST_DTAG = 16'h0001; // VID 1, pcp 0.
	localparam logic [1:0]  QS_ONE   = 2'h0; // One queue.
	localparam logic [1:0]  QS_TWO   = 2'h1; // Two queues.
	localparam logic [1:0]  QS_FOUR  = 2'h2; // Four queues.
	localparam logic [15:0] TPID     = 16'h8100; // Tag identifier.
	localparam logic [15:0] ETH_IP4  = 16'h0800; // IPv4 type.
	localparam logic [4:0]  POS_TAG  = 5'd12; // Tag byte offset.
	localparam logic [4:0]  POS_TCI  = 5'd14; // First TCI byte.
	localparam logic [4:0]  POS_TOS  = 5'd15; // IPv4 ToS byte.
	localparam int          NPORT    = 5;     // Switch ports.

	// Egress editor states.
	typedef enum logic [2:0] {
		EG_HDR, EG_HOLD, EG_INS, EG_EMIT, EG_DROP, EG_BODY, EG_FCS
	} qostg_eg_t;

	// Folds one byte into a reflected CRC-32 remainder.
	function automatic logic [31:0] qostg_crc8(
		input logic [31:0] c,
		input logic [7:0]  d
	);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
		end
		return r;
	endfunction

endpackage

/* design/qostg_sched.sv */
// Purpose: Picks the next transmit queue of one egress port.
// Assumes: Q_PEND bits are queue-not-empty levels.
// Notes:   One grant per request, answered on the next edge.
module qostg_sched (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Configuration.
	input  wire logic [1:0] split,
	input  wire logic       wfq,
	input  wire logic [27:0] wgt,
	// Request and grant.
	input  wire logic [3:0] pend,
	input  wire logic       req,
	output logic            gnt,
	output logic [1:0]      queue
);

	// ------------------------------
	// Selection
	// ------------------------------
	logic [6:0] cr_r [4];   // Remaining credit per queue.
	logic [3:0] avail;      // Queues usable in this split mode.
	logic [3:0] elig;       // Pending queues holding credit.
	logic [3:0] cand;       // Candidates for this pick.
	logic       reload;     // Credit round exhausted.
	logic [1:0] pick;       // Highest candidate.

	// Single queue uses q0 only; two queues use q1 over q0.
	assign avail = (split == qostg_pkg::QS_FOUR) ? 4'hf :
		(split == qostg_pkg::QS_TWO) ? 4'h3 : 4'h1; // [RL1] [RL3]

	// Scan upward so the highest index wins.
	always_comb begin
		elig   = '0;
		for (int i = 0; i < 4; i++) begin
			elig[i] = pend[i] && avail[i] && (cr_r[i] != 7'h00);
		end
		reload = (split == qostg_pkg::QS_FOUR) && wfq && (elig == 4'h0);
		cand   = (split == qostg_pkg::QS_FOUR && wfq && !reload) ?
			elig : (pend & avail); // [RL4]
		pick   = 2'h0;
		for (int i = 0; i < 4; i++) begin
			if (cand[i]) begin
				pick = 2'(i); // [RL2]
			end
		end
	end

	// ------------------------------
	// Grant and credit registers
	// ------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			gnt   <= 1'b0;
			queue <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				cr_r[i] <= 7'h00;
			end
		end else begin
			gnt <= req && (cand != 4'h0);
			if (req && cand != 4'h0) begin
				queue <= pick;
				// A new round reloads all weights before spending.
				for (int i = 0; i < 4; i++) begin
					if (reload) begin
						cr_r[i] <= wgt[i*7 +: 7] - 7'(i == int'(pick));
					end else if (i == int'(pick) && cr_r[i] != 7'h00) begin
						cr_r[i] <= cr_r[i] - 7'h01; // [RL4]
					end
				end
			end
		end
	end

endmodule

/* design/qostg_port.sv */
// Purpose: Ingress classification and egress tag editing of one port.
// Assumes: Frames arrive without FCS; FCS is appended on TX.
// Notes:   PORT_NUM names this port among the five default tags.
//
// Strobed register access and the register offsets were left to the implementer.
module qostg_port #(
	parameter int PORT_NUM = 0
) (
	// Clock and reset.
	input  wire logic       CLK,
	input  wire logic       RST,
	// Register port.
	input  wire logic [7:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	output logic [7:0]      REG_RDATA,
	// Ingress stream from the link.
	input  wire logic       RX_VALID,
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_SOP,
	input  wire logic       RX_EOP,
	output logic            RX_READY,
	// Classified stream to the fabric.
	output logic            FAB_VALID,
	output logic [7:0]      FAB_DATA,
	output logic            FAB_SOP,
	output logic            FAB_EOP,
	output logic [1:0]      FAB_PRIO,
	input  wire logic       FAB_READY,
	// Queue selection at this egress port.
	input  wire logic       ENQ_VALID,
	input  wire logic [1:0] ENQ_PRIO,
	output logic            ENQ_QVALID,
	output logic [1:0]      ENQ_QUEUE,
	// Transmit scheduling.
	input  wire logic [3:0] Q_PEND,
	input  wire logic       SCH_REQ,
	output logic            SCH_GNT,
	output logic [1:0]      SCH_QUEUE,
	// Egress stream from the fabric.
	input  wire logic       EG_VALID,
	input  wire logic [7:0] EG_DATA,
	input  wire logic       EG_SOP,
	input  wire logic       EG_EOP,
	input  wire logic [2:0] EG_SRC,
	output logic            EG_READY,
	// Edited stream to the link, FCS included.
	output logic            TX_VALID,
	output logic [7:0]      TX_DATA,
	output logic            TX_SOP,
	output logic            TX_EOP,
	input  wire logic       TX_READY
);

	// ------------------------------
	// Register file
	// ------------------------------
	logic [7:0]   ctrl0_r, ctrl2_r, ctrl9_r; // Port controls.
	logic [4:0]   memb_r;                    // Insert sources.
	logic [27:0]  wgt_r;                     // Weights q0..q3.
	logic [15:0]  pmap_r;                    // 802.1p map.
	logic [1:0]   q2m_r;                     // Two-queue map.
	logic [127:0] dscp_r;                    // DSCP map.
	logic [15:0]  dtag_r [qostg_pkg::NPORT]; // Default tags.
	logic [7:0]   stat;                      // Status byte.
	logic [1:0]   split;                     // Queue split code.
	logic [7:0]   dt_idx;                    // Default tag index.
	logic         wr_w, wr_dscp, wr_dtag;    // Array writes.
	logic [1:0]   w_q;                       // Weight queue.

	assign split   = {ctrl9_r[qostg_pkg::B_SPLIT_HI],
		ctrl0_r[qostg_pkg::B_SPLIT_LO]}; // [RL1]
	assign dt_idx  = REG_ADDR - qostg_pkg::OFF_DTAG;
	assign w_q     = 2'(3 - (REG_ADDR - qostg_pkg::OFF_WGT));
	assign wr_w    = REG_WR && REG_ADDR >= qostg_pkg::OFF_WGT &&
		REG_ADDR < qostg_pkg::OFF_WGT + 8'h04;
	assign wr_dscp = REG_WR && REG_ADDR[7:4] == qostg_pkg::OFF_DSCP[7:4];
	assign wr_dtag = REG_WR && dt_idx < 8'(2 * qostg_pkg::NPORT);

	// Software writes, one register per address.
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl0_r <= qostg_pkg::RST_CTRL;
			ctrl2_r <= qostg_pkg::RST_CTRL;
			ctrl9_r <= qostg_pkg::RST_CTRL;
			memb_r  <= qostg_pkg::RST_MEMB;
			wgt_r   <= {qostg_pkg::RST_W3, qostg_pkg::RST_W2,
				qostg_pkg::RST_W1, qostg_pkg::RST_W0}; // [RL4]
			pmap_r  <= qostg_pkg::RST_PMAP;
			q2m_r   <= qostg_pkg::RST_Q2M;
			dscp_r  <= '0;
			for (int i = 0; i < qostg_pkg::NPORT; i++) begin
				dtag_r[i] <= qostg_pkg::RST_DTAG;
			end
		end else begin
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_CTRL0) begin
				ctrl0_r <= REG_WDATA;
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_CTRL2) begin
				ctrl2_r <= REG_WDATA;
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_CTRL9) begin
				ctrl9_r <= REG_WDATA;
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_MEMB) begin
				memb_r <= REG_WDATA[4:0]; // [RL11]
			end
			if (wr_w) begin
				wgt_r[w_q*7 +: 7] <= REG_WDATA[6:0]; // [RL4]
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_PMAP) begin
				pmap_r[7:0] <= REG_WDATA; // [RL8]
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_PMAP + 8'h01) begin
				pmap_r[15:8] <= REG_WDATA;
			end
			if (REG_WR && REG_ADDR == qostg_pkg::OFF_GLOB) begin
				q2m_r <= REG_WDATA[qostg_pkg::B_Q2MAP +: 2]; // [RL5]
			end
			if (wr_dscp) begin
				dscp_r[REG_ADDR[3:0]*8 +: 8] <= REG_WDATA; // [RL19]
			end
			if (wr_dtag) begin
				// Even index holds the high byte of a port's tag.
				dtag_r[dt_idx[3:1]][(dt_idx[0] ? 0 : 8) +: 8]
					<= REG_WDATA; // [RL17]
			end
		end
	end

	// Read data stand the cycle after the strobe; unmapped reads 0.
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (REG_ADDR == qostg_pkg::OFF_CTRL0) rd_mux = ctrl0_r;
		if (REG_ADDR == qostg_pkg::OFF_CTRL2) rd_mux = ctrl2_r;
		if (REG_ADDR == qostg_pkg::OFF_CTRL9) rd_mux = ctrl9_r;
		if (REG_ADDR == qostg_pkg::OFF_MEMB) rd_mux = {3'h0, memb_r};
		if (wr_w || (REG_RD && REG_ADDR >= qostg_pkg::OFF_WGT &&
			REG_ADDR < qostg_pkg::OFF_WGT + 8'h04)) begin
			rd_mux = {1'b0, wgt_r[w_q*7 +: 7]};
		end
		if (REG_ADDR == qostg_pkg::OFF_PMAP) rd_mux = pmap_r[7:0];
		if (REG_ADDR == qostg_pkg::OFF_PMAP + 8'h01) begin
			rd_mux = pmap_r[15:8];
		end
		if (REG_ADDR == qostg_pkg::OFF_GLOB) rd_mux = {q2m_r, 6'h00};
		if (REG_ADDR[7:4] == qostg_pkg::OFF_DSCP[7:4]) begin
			rd_mux = dscp_r[REG_ADDR[3:0]*8 +: 8];
		end
		if (dt_idx < 8'(2 * qostg_pkg::NPORT)) begin
			rd_mux = dtag_r[dt_idx[3:1]][(dt_idx[0] ? 0 : 8) +: 8];
		end
		if (REG_ADDR == qostg_pkg::OFF_STAT) rd_mux = stat;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else begin
			REG_RDATA <= REG_RD ? rd_mux : 8'h00;
		end
	end

	// ------------------------------
	// Ingress classification and priority cap
	// ------------------------------
	logic [4:0]  rx_cnt_r;    // Byte index, saturating.
	logic [7:0]  rx_b12_r;    // Byte 12 kept for type check.
	logic        rx_tag_r;    // Frame carries a tag.
	logic        rx_ip_r;     // Untagged IPv4 frame.
	logic [2:0]  rx_pcp_r;    // Priority after the cap.
	logic [5:0]  rx_dscp_r;   // Code point of an IP frame.
	logic        rx_take;     // Byte moves this cycle.
	logic [2:0]  own_pcp;     // Default tag priority.
	logic        cap_hit;     // Byte 14 priority exceeds cap.
	logic [7:0]  rx_byte;     // Byte after any rewrite.
	logic [1:0]  rx_prio;     // Classified level.

	assign RX_READY = !FAB_VALID || FAB_READY;
	assign rx_take  = RX_VALID && RX_READY;
	assign own_pcp  = dtag_r[PORT_NUM][15:13];
	assign cap_hit  = ctrl2_r[qostg_pkg::B_CAP] && rx_tag_r &&
		rx_cnt_r == qostg_pkg::POS_TCI && RX_DATA[7:5] > own_pcp;
	assign rx_byte  = cap_hit ? {own_pcp, RX_DATA[4:0]} : RX_DATA; // [RL16]

	// 802.1p first, then DSCP, then the port's own level.
	assign rx_prio =
		(ctrl0_r[qostg_pkg::B_DOT1P] && rx_tag_r) ?
			pmap_r[rx_pcp_r*2 +: 2] :                   // [RL8] [RL9]
		(ctrl0_r[qostg_pkg::B_DSCP] && rx_ip_r) ?
			dscp_r[rx_dscp_r*2 +: 2] :                  // [RL19]
			ctrl0_r[qostg_pkg::B_PPRIO +: 2];           // [RL6]

	// Header bytes are parsed as they pass.
	always_ff @(posedge CLK) begin
		if (RST) begin
			rx_cnt_r  <= 5'd0;
			rx_b12_r  <= 8'h00;
			rx_tag_r  <= 1'b0;
			rx_ip_r   <= 1'b0;
			rx_pcp_r  <= 3'h0;
			rx_dscp_r <= 6'h00;
		end else if (rx_take) begin
			rx_cnt_r <= RX_EOP ? 5'd0 :
				(rx_cnt_r == 5'd31) ? rx_cnt_r : rx_cnt_r + 5'd1;
			if (RX_SOP) begin
				rx_tag_r <= 1'b0;
				rx_ip_r  <= 1'b0;
			end
			if (rx_cnt_r == qostg_pkg::POS_TAG) rx_b12_r <= RX_DATA;
			if (rx_cnt_r == qostg_pkg::POS_TAG + 5'd1) begin
				rx_tag_r <= {rx_b12_r, RX_DATA} == qostg_pkg::TPID; // [RL10]
				rx_ip_r  <= {rx_b12_r, RX_DATA} == qostg_pkg::ETH_IP4;
			end
			if (rx_cnt_r == qostg_pkg::POS_TCI) rx_pcp_r <= rx_byte[7:5];
			if (rx_cnt_r == qostg_pkg::POS_TOS) rx_dscp_r <= RX_DATA[7:2];
		end
	end

	// Output stage toward the fabric; level stands with the last byte.
	always_ff @(posedge CLK) begin
		if (RST) begin
			FAB_VALID <= 1'b0;
			FAB_DATA  <= 8'h00;
			FAB_SOP   <= 1'b0;
			FAB_EOP   <= 1'b0;
			FAB_PRIO  <= 2'h0;
		end else if (RX_READY) begin
			FAB_VALID <= RX_VALID;
			FAB_DATA  <= rx_byte;
			FAB_SOP   <= RX_VALID && RX_SOP;
			FAB_EOP   <= RX_VALID && RX_EOP;
			FAB_PRIO  <= rx_prio;
		end
	end

	// ------------------------------
	// Queue mapping and scheduling
	// ------------------------------
	logic hi_q;   // Two-queue mode sends to the high queue.

	assign hi_q = ENQ_PRIO >= q2m_r || ENQ_PRIO == 2'h3; // [RL5] [RL7]

	always_ff @(posedge CLK) begin
		if (RST) begin
			ENQ_QVALID <= 1'b0;
			ENQ_QUEUE  <= 2'h0;
		end else begin
			ENQ_QVALID <= ENQ_VALID;
			ENQ_QUEUE  <= (split == qostg_pkg::QS_FOUR) ? ENQ_PRIO : // [RL18]
				(split == qostg_pkg::QS_TWO) ? {1'b0, hi_q} : 2'h0; // [RL3]
		end
	end

	qostg_sched u_sched (
		.clk   (CLK),
		.rst   (RST),
		.split (split),
		.wfq   (ctrl9_r[qostg_pkg::B_WFQ]),
		.wgt   (wgt_r),
		.pend  (Q_PEND),
		.req   (SCH_REQ),
		.gnt   (SCH_GNT),
		.queue (SCH_QUEUE)
	);

	// ------------------------------
	// Egress tag editor with FCS regeneration
	// ------------------------------
	qostg_pkg::qostg_eg_t eg_r, eg_nxt; // Editor state.
	logic [3:0]  eg_cnt_r;  // Header byte index up to 12.
	logic [1:0]  eg_idx_r;  // Step inside INS, EMIT, DROP, FCS.
	logic [7:0]  h0_r, h1_r; // Held bytes 12 and 13.
	logic        h1_eop_r;  // Byte 13 ended the frame.
	logic [2:0]  src_r;     // Ingress port of this frame.
	logic [31:0] crc_r;     // Running remainder.
	logic        adv;       // Output stage can load.
	logic        ld;        // Load a byte this cycle.
	logic [7:0]  ld_data;   // Byte to load.
	logic        in_last;   // Taken byte is the frame's last.
	logic        is_tag;    // Held type field equals TPID.
	logic        ins_ok;    // Insertion allowed for this source.
	logic [15:0] src_tag;   // Default tag of the source port.
	logic [31:0] fcs;       // Complemented remainder.

	assign adv     = !TX_VALID || TX_READY;
	assign is_tag  = {h0_r, EG_DATA} == qostg_pkg::TPID; // [RL10]
	assign src_tag = (src_r < 3'(qostg_pkg::NPORT)) ?
		dtag_r[src_r] : qostg_pkg::RST_DTAG;
	assign ins_ok  = ctrl0_r[qostg_pkg::B_INSERT] &&
		src_r < 3'(qostg_pkg::NPORT) && memb_r[src_r]; // [RL11]
	assign fcs     = ~crc_r;
	assign in_last = EG_VALID && EG_READY && EG_EOP;

	// Decides what moves: inputs taken, bytes loaded, next state.
	always_comb begin
		eg_nxt   = eg_r;
		EG_READY = 1'b0;
		ld       = 1'b0;
		ld_data  = EG_DATA;
		unique case (eg_r)
			qostg_pkg::EG_HDR, qostg_pkg::EG_BODY: begin
				EG_READY = adv;
				ld = EG_VALID && adv &&
					!(eg_r == qostg_pkg::EG_HDR &&
					eg_cnt_r == 4'(qostg_pkg::POS_TAG) && !EG_EOP);
				if (EG_VALID && adv) begin
					eg_nxt = EG_EOP ? qostg_pkg::EG_FCS :
						ld ? eg_r : qostg_pkg::EG_HOLD;
				end
			end
			qostg_pkg::EG_HOLD: begin
				EG_READY = 1'b1;
				if (EG_VALID) begin
					if (is_tag && ctrl0_r[qostg_pkg::B_REMOVE] && !EG_EOP) begin
						eg_nxt = qostg_pkg::EG_DROP; // [RL14]
					end else if (!is_tag && ins_ok) begin
						eg_nxt = qostg_pkg::EG_INS; // [RL12] [RL13]
					end else begin
						eg_nxt = qostg_pkg::EG_EMIT;
					end
				end
			end
			qostg_pkg::EG_INS: begin
				ld = adv;
				ld_data = (eg_idx_r == 2'd0) ? qostg_pkg::TPID[15:8] :
					(eg_idx_r == 2'd1) ? qostg_pkg::TPID[7:0] :
					(eg_idx_r == 2'd2) ? src_tag[15:8] : src_tag[7:0];
				if (adv && eg_idx_r == 2'd3) eg_nxt = qostg_pkg::EG_EMIT;
			end
			qostg_pkg::EG_EMIT: begin
				ld = adv;
				ld_data = eg_idx_r[0] ? h1_r : h0_r;
				if (adv && eg_idx_r[0]) begin
					eg_nxt = h1_eop_r ? qostg_pkg::EG_FCS : qostg_pkg::EG_BODY;
				end
			end
			qostg_pkg::EG_DROP: begin
				EG_READY = 1'b1;
				if (EG_VALID) begin
					eg_nxt = EG_EOP ? qostg_pkg::EG_FCS :
						eg_idx_r[0] ? qostg_pkg::EG_BODY : eg_r;
				end
			end
			qostg_pkg::EG_FCS: begin
				ld = adv;
				ld_data = fcs[eg_idx_r*8 +: 8]; // [RL15]
				if (adv && eg_idx_r == 2'd3) eg_nxt = qostg_pkg::EG_HDR;
			end
			default: eg_nxt = qostg_pkg::EG_HDR;
		endcase
	end

	// Editor bookkeeping; step index restarts on each state change.
	always_ff @(posedge CLK) begin
		if (RST) begin
			eg_r     <= qostg_pkg::EG_HDR;
			eg_cnt_r <= 4'd0;
			eg_idx_r <= 2'd0;
			h0_r     <= 8'h00;
			h1_r     <= 8'h00;
			h1_eop_r <= 1'b0;
			src_r    <= 3'd0;
		end else begin
			eg_r <= eg_nxt;
			eg_idx_r <= (eg_nxt != eg_r) ? 2'd0 :
				(ld || (eg_r == qostg_pkg::EG_DROP && EG_VALID)) ?
				eg_idx_r + 2'd1 : eg_idx_r;
			if (eg_r == qostg_pkg::EG_HDR && EG_VALID && adv) begin
				eg_cnt_r <= eg_cnt_r + 4'd1;
				if (EG_SOP) src_r <= EG_SRC;
				h0_r <= EG_DATA;
			end
			if (eg_nxt == qostg_pkg::EG_HDR && eg_r != qostg_pkg::EG_HDR) begin
				eg_cnt_r <= 4'd0;
			end
			if (eg_r == qostg_pkg::EG_HDR && in_last) eg_cnt_r <= 4'd0;
			if (eg_r == qostg_pkg::EG_HOLD && EG_VALID) begin
				h1_r     <= EG_DATA;
				h1_eop_r <= EG_EOP;
			end
		end
	end

	// Output stage to the link; the remainder covers every data byte.
	always_ff @(posedge CLK) begin
		if (RST) begin
			TX_VALID <= 1'b0;
			TX_DATA  <= 8'h00;
			TX_SOP   <= 1'b0;
			TX_EOP   <= 1'b0;
			crc_r    <= 32'hffffffff;
		end else if (adv) begin
			TX_VALID <= ld;
			TX_DATA  <= ld_data;
			TX_SOP   <= ld && eg_r == qostg_pkg::EG_HDR && eg_cnt_r == 4'd0;
			TX_EOP   <= ld && eg_r == qostg_pkg::EG_FCS && eg_idx_r == 2'd3;
			if (ld && eg_r != qostg_pkg::EG_FCS) begin
				crc_r <= qostg_pkg::qostg_crc8(
					(eg_r == qostg_pkg::EG_HDR && eg_cnt_r == 4'd0) ?
					32'hffffffff : crc_r, ld_data); // [RL15]
			end
		end
	end

	// Status: last granted queue, editor busy, ingress tag seen.
	assign stat = {3'h0, rx_tag_r, rx_cnt_r != 5'd0,
		eg_r != qostg_pkg::EG_HDR, SCH_QUEUE};

endmodule

/* tb/qostg_port_asserts.sv */
// Purpose: Assertions on the pins of qostg_port.
// Assumes: Split and WFQ bits are mirrored from register writes.
// Notes:   Bound to every qostg_port instance.
module qostg_port_chk (
	// Clock, reset and register port.
	input wire logic       CLK, RST, REG_WR, REG_RD,
	input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, TX_DATA,
	// Stream and queue handshakes.
	input wire logic       RX_VALID, RX_READY, FAB_VALID, ENQ_VALID,
	input wire logic       ENQ_QVALID, SCH_REQ, SCH_GNT, TX_VALID, TX_READY,
	input wire logic [1:0] ENQ_PRIO, ENQ_QUEUE, SCH_QUEUE,
	input wire logic [3:0] Q_PEND
);
	logic [1:0] c9_r; // Split-high and WFQ bits.
	logic       c0_r; // Split-low bit.
	wire logic [1:0] split = {c9_r[1], c0_r};
	wire logic [1:0] top = Q_PEND[3] ? 2'h3 :
		Q_PEND[2] ? 2'h2 : {1'b0, Q_PEND[1]};
	// Mirrors the queue setup.
	always_ff @(posedge CLK) begin
		if (RST)
			{c9_r, c0_r} <= 3'h0;
		else if (REG_WR && REG_ADDR == 8'h09)
			c9_r <= REG_WDATA[1:0];
		else if (REG_WR && REG_ADDR == 8'h00)
			c0_r <= REG_WDATA[0];
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("stray read data");
	one_q_a: assert property (ENQ_VALID && split[0] == split[1]
		|=> ENQ_QVALID && ENQ_QUEUE == 2'h0) else $error("one queue");
	two_q_a: assert property (ENQ_VALID && split == 2'h1 &&
		ENQ_PRIO == 2'h3 |=> ENQ_QUEUE == 2'h1) else $error("two queue");
	four_q_a: assert property (ENQ_VALID && split == 2'h2
		|=> ENQ_QUEUE == $past(ENQ_PRIO)) else $error("four queue");
	strict_pick_a: assert property (SCH_REQ && split == 2'h2 &&
		!c9_r[0] && Q_PEND != 4'h0 |=> SCH_GNT && SCH_QUEUE == $past(top))
		else $error("strict pick");
	gnt_cause_a: assert property (SCH_GNT |-> $past(SCH_REQ) &&
		$past(Q_PEND) != 4'h0) else $error("stray grant");
	tx_hold_a: assert property (TX_VALID && !TX_READY
		|=> TX_VALID && $stable(TX_DATA)) else $error("tx not held");
	fab_take_a: assert property (RX_VALID && RX_READY |=> FAB_VALID)
		else $error("ingress byte lost");
	cover property (SCH_GNT);
	cover property (ENQ_QVALID && ENQ_QUEUE == 2'h3);
	cover property (TX_VALID && !TX_READY);
endmodule
bind qostg_port qostg_port_chk u_qostg_port_chk (.*);

/* tb/qostg_link.sv */
// Purpose: Link partner sending ingress frames and taking transmit bytes.
// Assumes: One frame at a time in each direction.
// Notes:   Transmit ready drops one cycle in three.
module qostg_link (
	input  wire logic       CLK,
	output logic            RX_VALID, RX_SOP, RX_EOP,
	output logic [7:0]      RX_DATA,
	input  wire logic       RX_READY, TX_VALID, TX_EOP,
	input  wire logic [7:0] TX_DATA,
	output logic            TX_READY
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$]; // Bytes taken from the transmit side.
	int         nfr = 0; // Frames completed.
	int         cyc = 0; // Stall pattern counter.
	initial {RX_VALID, RX_SOP, RX_EOP, RX_DATA, TX_READY} = 12'h000;
	// Takes transmit bytes, stalling now and then.
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		TX_READY <= (cyc % 3) != 0;
		if (TX_VALID && TX_READY) begin
			got.push_back(TX_DATA);
			if (TX_EOP) nfr <= nfr + 1;
		end
	end
	// Sends a frame; released data show the inverse.
	task automatic send(input logic [7:0] f[$]);
		for (int i = 0; i < f.size(); i++) begin
			@(posedge CLK);
			{RX_VALID, RX_SOP, RX_EOP} <= {1'b1, i == 0, i == f.size() - 1};
			RX_DATA <= f[i];
			@(negedge CLK);
			for (int k = 0; !RX_READY && k < 50; k++) @(negedge CLK);
		end
		@(posedge CLK);
		RX_VALID <= 1'b0;
		RX_DATA <= ~RX_DATA;
	endtask
endmodule

/* tb/test_qostg_port.sv */
// Purpose: Self-checking bench of qostg_port.
// Assumes: Port 0 default tag; fabric side always ready.
// Notes:   FCS checked by the CRC-32 residue.
module test_qostg_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, FAB_READY = 1;
	logic ENQ_VALID = 0, SCH_REQ = 0, EG_VALID = 0, EG_SOP = 0, EG_EOP = 0;
	logic [7:0] REG_ADDR = 0, REG_WDATA = 0, EG_DATA = 0;
	logic [7:0] REG_RDATA, FAB_DATA, TX_DATA, RX_DATA;
	logic [1:0] ENQ_PRIO = 0, FAB_PRIO, ENQ_QUEUE, SCH_QUEUE, lvl;
	logic [3:0] Q_PEND = 0;
	logic [2:0] EG_SRC = 0;
	logic RX_VALID, RX_SOP, RX_EOP, RX_READY, FAB_VALID, FAB_SOP, FAB_EOP;
	logic ENQ_QVALID, SCH_GNT, EG_READY, TX_VALID, TX_SOP, TX_EOP, TX_READY;
	logic [7:0] fab[$], f[$], g[$]; // Fabric bytes, frame, transmit bytes.
	int err_total = 0, n_checks = 0;
	qostg_port u_qostg_port (.*);
	qostg_link u_qostg_link (.*);
	initial forever #4 CLK = ~CLK;
	// Collects the classified ingress stream.
	always @(posedge CLK) if (FAB_VALID && FAB_READY) begin
		fab.push_back(FAB_DATA);
		if (FAB_EOP) lvl <= FAB_PRIO;
	end
	task automatic chk(input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge CLK);
		{REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
		@(posedge CLK);
		REG_WR <= 0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge CLK);
		{REG_RD, REG_ADDR} <= {1'b1, a};
		@(posedge CLK);
		REG_RD <= 0;
		@(negedge CLK);
		chk(REG_RDATA, e);
	endtask
	task automatic enq(input logic [1:0] p, e);
		@(posedge CLK);
		{ENQ_VALID, ENQ_PRIO} <= {1'b1, p};
		@(posedge CLK);
		ENQ_VALID <= 0;
		@(negedge CLK);
		chk({ENQ_QVALID, ENQ_QUEUE}, {1'b1, e});
	endtask
	// Sends an egress frame, waits for its copy.
	task automatic eg(input logic [7:0] fr[$]);
		int n;
		n = u_qostg_link.nfr;
		u_qostg_link.got.delete();
		for (int i = 0; i < fr.size(); i++) begin
			@(posedge CLK);
			{EG_VALID, EG_SOP, EG_EOP} <= {1'b1, i == 0, i == fr.size() - 1};
			EG_DATA <= fr[i];
			@(negedge CLK);
			for (int k = 0; !EG_READY && k < 50; k++) @(negedge CLK);
		end
		@(posedge CLK);
		EG_VALID <= 0;
		for (int k = 0; u_qostg_link.nfr == n && k < 200; k++) @(posedge CLK);
		if (u_qostg_link.nfr == n) err_total++;
		g = u_qostg_link.got;
	endtask
	function automatic void mk(input logic [15:0] ty);
		f = {};
		for (int i = 0; i < 20; i++) f.push_back(i[7:0]);
		{f[12], f[13]} = ty;
	endfunction
	function automatic logic [31:0] resid(input logic [7:0] q[$]);
		logic [31:0] c = 32'hffffffff;
		foreach (q[i]) begin
			c ^= {24'h000000, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		end
		return c;
	endfunction
	task automatic final_report;
		if (err_total == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge CLK);
		err_total++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge CLK);
		RST <= 0;
		rd(8'h00, 8'h00);
		rd(8'h08, 8'h1f);
		rd(8'h0e, 8'h08);
		rd(8'h11, 8'h01);
		rd(8'h21, 8'hfa);
		rd(8'h22, 8'h80);
		rd(8'h41, 8'h01);
		rd(8'h7f, 8'h00);
		// Every split code against each level.
		for (int s = 0; s < 4; s++) begin
			wr(8'h09, {6'h00, s[1], 1'b0});
			wr(8'h00, {7'h00, s[0]});
			for (int p = 0; p < 4; p++)
				enq(p[1:0], s == 2 ? p[1:0] : s == 1 && p > 1);
		end
		wr(8'h00, 8'h00);
		@(posedge CLK);
		{Q_PEND, SCH_REQ} <= {4'h6, 1'b1};
		@(posedge CLK);
		SCH_REQ <= 0;
		@(negedge CLK);
		chk({SCH_GNT, SCH_QUEUE}, 3'h6);
		// Tagged pcp 6 capped to the default pcp 3.
		wr(8'h40, 8'h60);
		wr(8'h00, 8'h20);
		wr(8'h02, 8'h80);
		mk(16'h8100);
		f[14] = 8'hc0;
		u_qostg_link.send(f);
		repeat (3) @(posedge CLK);
		chk(fab[14], 8'h60);
		chk(lvl, 2'h1);
		wr(8'h00, 8'h10);
		u_qostg_link.send(f);
		repeat (3) @(posedge CLK);
		chk(lvl, 2'h2);
		// Egress insertion, tagged passthrough and removal.
		wr(8'h40, 8'h2a);
		wr(8'h41, 8'h05);
		wr(8'h00, 8'h04);
		mk(16'h88b5);
		eg(f);
		chk(g.size(), 28);
		chk({g[12], g[13], g[14], g[15]}, 32'h81002a05);
		chk(resid(g), 32'hdebb20e3);
		mk(16'h8100);
		eg(f);
		chk(g.size(), 24);
		wr(8'h00, 8'h02);
		eg(f);
		chk(g.size(), 20);
		chk(g[12], 8'h10);
		chk(resid(g), 32'hdebb20e3);
		final_report();
	end
endmodule
